// ---- rtl/gpgc_pkg.sv ----
`default_nettype none
package gpgc_pkg;
  // bus shape
  localparam int unsigned GPGC_HADDR_W = 32;
  localparam int unsigned GPGC_HDATA_W = 32;
  localparam int unsigned GPGC_IDX_LSB = 2;
  localparam logic [1:0] GPGC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] GPGC_HRESP_OKAY = 2'h0;

  // register indices; byte address is four times the index
  localparam logic [7:0] GPGC_IDX_DRV_EN = 8'h00;
  localparam logic [7:0] GPGC_IDX_DRV_EN_SET = 8'h01;
  localparam logic [7:0] GPGC_IDX_DRV_EN_CLR = 8'h02;
  localparam logic [7:0] GPGC_IDX_DRV_EN_TGL = 8'h03;
  localparam logic [7:0] GPGC_IDX_DRV_LVL = 8'h04;
  localparam logic [7:0] GPGC_IDX_DRV_LVL_SET = 8'h05;
  localparam logic [7:0] GPGC_IDX_DRV_LVL_CLR = 8'h06;
  localparam logic [7:0] GPGC_IDX_DRV_LVL_TGL = 8'h07;
  localparam logic [7:0] GPGC_IDX_SAMPLED_IN = 8'h08;
  localparam logic [7:0] GPGC_IDX_EVENT_FLAGS = 8'h09;
  localparam logic [7:0] GPGC_IDX_GROUP_CTRL = 8'h0a;
  localparam logic [7:0] GPGC_IDX_STAGED_SETUP = 8'h0b;
  localparam logic [7:0] GPGC_IDX_BULK_COPY = 8'h0c;
  localparam logic [7:0] GPGC_IDX_BULK_OR = 8'h0d;
  localparam logic [7:0] GPGC_IDX_BULK_ANDNOT = 8'h0e;
  localparam logic [7:0] GPGC_IDX_PIN_CFG_BASE = 8'h10;
  // fast alias bank
  localparam logic [7:0] GPGC_IDX_ALIAS_DRV_EN = 8'h20;
  localparam logic [7:0] GPGC_IDX_ALIAS_DRV_LVL = 8'h21;
  localparam logic [7:0] GPGC_IDX_ALIAS_SAMPLED_IN = 8'h22;
  localparam logic [7:0] GPGC_IDX_ALIAS_EVENT_FLAGS = 8'h23;

  // per-pin configuration fields
  localparam int unsigned GPGC_CFG_SENSE_LSB = 0;
  localparam int unsigned GPGC_CFG_PULLUP_BIT = 3;
  localparam int unsigned GPGC_CFG_THRESH_BIT = 6;
  localparam int unsigned GPGC_CFG_POLARITY_BIT = 7;
  localparam logic [7:0] GPGC_CFG_USED_MASK = 8'hcf;
  localparam int unsigned GPGC_SLEW_BIT = 0;

  // sense field encodings
  localparam logic [2:0] GPGC_SENSE_NONE = 3'h0;
  localparam logic [2:0] GPGC_SENSE_BOTH = 3'h1;
  localparam logic [2:0] GPGC_SENSE_RISE = 3'h2;
  localparam logic [2:0] GPGC_SENSE_FALL = 3'h3;
  localparam logic [2:0] GPGC_SENSE_DISABLE = 3'h4;
  localparam logic [2:0] GPGC_SENSE_LOW = 3'h5;

  // values after reset
  localparam logic [7:0] GPGC_CFG_RESET = 8'h00;
  localparam logic [7:0] GPGC_STAGED_RESET = 8'h00;
  localparam logic GPGC_SLEW_RESET = 1'b0;
endpackage
`default_nettype wire

// ---- rtl/gpgc_top.sv ----
// Functional notes
// - reset: drivers off, input buffers on
// - enable bit drives; set strobe sets only
// - level set strobe sets written ones
// - level clear strobe clears written ones
// - toggle strobe or input write inverts level
// - enable zero releases; clear strobe clears only
// - enable toggle strobe flips pin direction
// - input disabled freezes buffer, synchronizer, sample
// - slew bit limits whole group at once
// - pin n config at base 0x10 plus n
// - polarity bit inverts input and output
// - polarity change yields internal edge
// - threshold bit picks Schmitt or TTL
// - pull-up on unless pin is driving
// - sense field picks interrupt condition
// - staged setup shared, masks per group
// - copy mask loads staged into selected pins
// - or mask merges staged into selected pins
// - andnot mask clears staged ones in pins
// - alias bank acts exactly like originals
// - peripheral override wins where it applies
// - input synchronised, readable in either direction
// - sense event sets flag; request follows flag
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module gpgc_top #(
  parameter int unsigned N_PINS = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [gpgc_pkg::GPGC_HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [gpgc_pkg::GPGC_HDATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [gpgc_pkg::GPGC_HDATA_W-1:0] hrdata,
  output logic [1:0] hresp,
  // pads
  input wire logic [N_PINS-1:0] pad_in,
  output logic [N_PINS-1:0] pad_out,
  output logic [N_PINS-1:0] pad_oe,
  output logic [N_PINS-1:0] pad_pull_up,
  output logic [N_PINS-1:0] pad_input_en,
  output logic [N_PINS-1:0] pad_thresh_ttl,
  output logic pad_slew_limit,
  // peripheral override
  input wire logic [N_PINS-1:0] periph_oe_take,
  input wire logic [N_PINS-1:0] periph_oe_val,
  input wire logic [N_PINS-1:0] periph_out_take,
  input wire logic [N_PINS-1:0] periph_out_val,
  output logic [N_PINS-1:0] pin_signal,
  // staged setup mirror between groups
  input wire logic staged_in_we,
  input wire logic [7:0] staged_in_data,
  output logic staged_out_we,
  output logic [7:0] staged_out_data,
  // interrupt request
  output logic pin_irq
);
  import gpgc_pkg::*;

  // alias indices fold onto the originals so both paths share one decoder
  function automatic logic [7:0] canon_idx(input logic [7:0] idx);
    logic [7:0] r;
    r = idx;
    case (idx)
      GPGC_IDX_ALIAS_DRV_EN: r = GPGC_IDX_DRV_EN;
      GPGC_IDX_ALIAS_DRV_LVL: r = GPGC_IDX_DRV_LVL;
      GPGC_IDX_ALIAS_SAMPLED_IN: r = GPGC_IDX_SAMPLED_IN;
      GPGC_IDX_ALIAS_EVENT_FLAGS: r = GPGC_IDX_EVENT_FLAGS;
      default: r = idx;
    endcase
    return r;
  endfunction

  function automatic logic sense_off(input logic [7:0] c);
    return c[GPGC_CFG_SENSE_LSB+:3] == GPGC_SENSE_DISABLE;
  endfunction

  // pin n's configuration word sits at the base index plus n; read and write share it
  function automatic logic cfg_hit(input logic [7:0] idx, input int n);
    return idx == GPGC_IDX_PIN_CFG_BASE + 8'(n);
  endfunction

  // sense condition met this cycle, from the internal level and its edges
  function automatic logic sense_hit(input logic [2:0] code, input logic lvl, input logic up, input logic down);
    logic r;
    r = 1'b0;
    case (code)
      GPGC_SENSE_BOTH: r = up | down;
      GPGC_SENSE_RISE: r = up;
      GPGC_SENSE_FALL: r = down;
      GPGC_SENSE_LOW: r = ~lvl;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // register state
  logic [N_PINS-1:0] drv_en, next_drv_en;
  logic [N_PINS-1:0] drv_lvl, next_drv_lvl;
  logic [N_PINS-1:0] flags, next_flags;
  logic slew, next_slew;
  logic [7:0] staged, next_staged;
  logic next_staged_we;
  // per-pin configuration words; the unused bits are never stored
  logic [7:0] cfg [N_PINS];
  logic [7:0] next_cfg [N_PINS];

  // input path
  logic [N_PINS-1:0] sampled;
  logic [N_PINS-1:0] internal_lvl;
  logic [N_PINS-1:0] pin_event;

  // bus phase state
  logic ph_valid, next_ph_valid;
  logic ph_write, next_ph_write;
  logic [7:0] ph_idx, next_ph_idx;
  logic next_hreadyout;
  logic [GPGC_HDATA_W-1:0] next_hrdata;

  // one wait state per transfer keeps read data coherent with a write
  // committed on the same edge, at the cost of bus throughput
  always_comb begin
    next_ph_valid = 1'b0;
    next_ph_write = ph_write;
    next_ph_idx = ph_idx;
    next_hreadyout = 1'b1;
    next_hrdata = hrdata;
    if (hsel && htrans == GPGC_HTRANS_NONSEQ && hready && hreadyout) begin
      next_ph_valid = 1'b1;
      next_ph_write = hwrite;
      next_ph_idx = canon_idx(haddr[GPGC_IDX_LSB+:8]);
      next_hreadyout = 1'b0;
    end else if (ph_valid) begin
      // taken in the data phase, so an earlier write is already visible
      next_hrdata = '0;
      if (!ph_write) begin
        next_hrdata[7:0] = read_value(ph_idx);
      end
    end
  end

  // no error case exists: unmapped and read-only accesses still end OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_idx <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= GPGC_HRESP_OKAY;
    end else begin
      ph_valid <= next_ph_valid;
      ph_write <= next_ph_write;
      ph_idx <= next_ph_idx;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= GPGC_HRESP_OKAY;
    end
  end

  // strobes and masks read as zero; unmapped indices too
  function automatic logic [7:0] read_value(input logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      GPGC_IDX_DRV_EN: r[N_PINS-1:0] = drv_en;
      GPGC_IDX_DRV_LVL: r[N_PINS-1:0] = drv_lvl;
      GPGC_IDX_SAMPLED_IN: r[N_PINS-1:0] = sampled;
      GPGC_IDX_EVENT_FLAGS: r[N_PINS-1:0] = flags;
      GPGC_IDX_GROUP_CTRL: r[GPGC_SLEW_BIT] = slew;
      GPGC_IDX_STAGED_SETUP: r = staged;
      default: begin
        for (int i = 0; i < N_PINS; i++) begin
          if (cfg_hit(idx, i)) r = cfg[i];
        end
      end
    endcase
    return r;
  endfunction

  // write decode
  // hwdata belongs to the data phase, one cycle after the address was taken
  logic wr;
  logic [N_PINS-1:0] wd;
  logic [7:0] wcfg;
  logic [N_PINS-1:0] flag_clr;
  assign wr = ph_valid && ph_write;
  assign wd = hwdata[N_PINS-1:0];
  assign wcfg = hwdata[7:0] & GPGC_CFG_USED_MASK;
  assign flag_clr = (wr && ph_idx == GPGC_IDX_EVENT_FLAGS) ? wd : '0;

  always_comb begin
    next_drv_en = drv_en;
    next_drv_lvl = drv_lvl;
    // a pin event in the clearing cycle survives the clear
    next_flags = (flags & ~flag_clr) | pin_event;
    next_slew = slew;
    next_staged = staged;
    next_staged_we = 1'b0;
    for (int i = 0; i < N_PINS; i++) begin
      next_cfg[i] = cfg[i];
    end
    // mirrored write from another group; a local write below takes over
    if (staged_in_we) next_staged = staged_in_data & GPGC_CFG_USED_MASK;
    if (wr) begin
      case (ph_idx)
        GPGC_IDX_DRV_EN: next_drv_en = wd;
        GPGC_IDX_DRV_EN_SET: next_drv_en = drv_en | wd;
        GPGC_IDX_DRV_EN_CLR: next_drv_en = drv_en & ~wd;
        GPGC_IDX_DRV_EN_TGL: next_drv_en = drv_en ^ wd;
        GPGC_IDX_DRV_LVL: next_drv_lvl = wd;
        GPGC_IDX_DRV_LVL_SET: next_drv_lvl = drv_lvl | wd;
        GPGC_IDX_DRV_LVL_CLR: next_drv_lvl = drv_lvl & ~wd;
        GPGC_IDX_DRV_LVL_TGL: next_drv_lvl = drv_lvl ^ wd;
        GPGC_IDX_SAMPLED_IN: next_drv_lvl = drv_lvl ^ wd;
        GPGC_IDX_GROUP_CTRL: next_slew = hwdata[GPGC_SLEW_BIT];
        // the broadcast pulse is for local writes only, so groups never echo
        GPGC_IDX_STAGED_SETUP: begin
          next_staged = wcfg;
          next_staged_we = 1'b1;
        end
        GPGC_IDX_BULK_COPY: begin
          // one write may rewrite every selected pin at once
          for (int i = 0; i < N_PINS; i++) begin
            if (wd[i]) next_cfg[i] = staged;
          end
        end
        GPGC_IDX_BULK_OR: begin
          // nonzero sense codes merge bitwise and may land on another code
          for (int i = 0; i < N_PINS; i++) begin
            if (wd[i]) next_cfg[i] = cfg[i] | staged;
          end
        end
        GPGC_IDX_BULK_ANDNOT: begin
          for (int i = 0; i < N_PINS; i++) begin
            if (wd[i]) next_cfg[i] = cfg[i] & ~staged;
          end
        end
        default: begin
          for (int i = 0; i < N_PINS; i++) begin
            if (cfg_hit(ph_idx, i)) next_cfg[i] = wcfg;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv_en <= '0;
      drv_lvl <= '0;
      flags <= '0;
      slew <= GPGC_SLEW_RESET;
      staged <= GPGC_STAGED_RESET;
      staged_out_we <= 1'b0;
      staged_out_data <= GPGC_STAGED_RESET;
      pin_irq <= 1'b0;
      for (int i = 0; i < N_PINS; i++) begin
        cfg[i] <= GPGC_CFG_RESET;
      end
    end else begin
      drv_en <= next_drv_en;
      drv_lvl <= next_drv_lvl;
      flags <= next_flags;
      slew <= next_slew;
      staged <= next_staged;
      staged_out_we <= next_staged_we;
      // staged value is shown every cycle so all groups see one storage
      staged_out_data <= next_staged;
      // request rises with the flag itself and falls with its clear
      pin_irq <= |next_flags;
      for (int i = 0; i < N_PINS; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  // per-pin input path and pad drive
  for (genvar g = 0; g < N_PINS; g++) begin : g_pin
    logic s1, s2, s3, filt, samp;
    logic next_s1, next_s2, next_s3, next_filt, next_samp;
    logic in_off, inv, rise, fall;
    logic next_oe, next_out, next_pull, next_sig;
    assign in_off = sense_off(cfg[g]);
    assign inv = cfg[g][GPGC_CFG_POLARITY_BIT];
    // the polarity bit sits after the filter, so flipping it is an edge
    assign internal_lvl[g] = filt ^ inv;
    assign rise = internal_lvl[g] & ~samp;
    assign fall = ~internal_lvl[g] & samp;

    always_comb begin
      next_s1 = s1;
      next_s2 = s2;
      next_s3 = s3;
      next_filt = filt;
      next_samp = samp;
      pin_event[g] = 1'b0;
      // while disabled the sampled bit holds; re-enabling may raise an edge
      if (!in_off) begin
        next_s1 = pad_in[g];
        next_s2 = s1;
        next_s3 = s2;
        // a one-cycle glitch between the last two stages is dropped
        if (s2 == s3) next_filt = s3;
        next_samp = internal_lvl[g];
        pin_event[g] = sense_hit(cfg[g][GPGC_CFG_SENSE_LSB+:3], internal_lvl[g], rise, fall);
      end
      // peripheral takes direction or level only where it asks to
      next_oe = periph_oe_take[g] ? periph_oe_val[g] : drv_en[g];
      // the polarity bit flips the stored level on its way to the pad
      next_out = periph_out_take[g] ? periph_out_val[g] : (drv_lvl[g] ^ inv);
      // pull-up follows the final direction, so a driving peripheral drops it too
      next_pull = cfg[g][GPGC_CFG_PULLUP_BIT] & ~next_oe;
      next_sig = in_off ? 1'b0 : internal_lvl[g];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        filt <= 1'b0;
        samp <= 1'b0;
        pad_oe[g] <= 1'b0;
        pad_out[g] <= 1'b0;
        pad_pull_up[g] <= 1'b0;
        pad_input_en[g] <= 1'b1;
        pad_thresh_ttl[g] <= 1'b0;
        pin_signal[g] <= 1'b0;
      end else begin
        s1 <= next_s1;
        s2 <= next_s2;
        s3 <= next_s3;
        filt <= next_filt;
        samp <= next_samp;
        pad_oe[g] <= next_oe;
        pad_out[g] <= next_out;
        pad_pull_up[g] <= next_pull;
        pad_input_en[g] <= ~in_off;
        pad_thresh_ttl[g] <= cfg[g][GPGC_CFG_THRESH_BIT];
        pin_signal[g] <= next_sig;
      end
    end
    assign sampled[g] = samp;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_slew_limit <= 1'b0;
    end else begin
      // one limit for the whole group; there is no per-pin control
      pad_slew_limit <= slew;
    end
  end

  // hsize is accepted but only whole-word access is meaningful
  logic unused_hsize;
  assign unused_hsize = ^{hsize, haddr[1:0]};
endmodule
`default_nettype wire

// ---- verif/gpgc_pad_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpgc_pad_model #(
  parameter int unsigned N_PINS = 8
) (
  // clock
  input wire logic clk,
  // pad side of the block
  input wire logic [N_PINS-1:0] pad_out,
  input wire logic [N_PINS-1:0] pad_oe,
  input wire logic [N_PINS-1:0] pad_pull_up,
  output logic [N_PINS-1:0] pad_in,
  // outside world
  input wire logic [N_PINS-1:0] ext_drv,
  input wire logic [N_PINS-1:0] ext_val
);
  logic [N_PINS-1:0] wobble = '0;
  // a floating pin must not settle to a friendly value
  always @(posedge clk) wobble <= ~wobble;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val) |
                  (~pad_oe & ~ext_drv & (pad_pull_up | wobble));
endmodule
`default_nettype wire

// ---- verif/gpgc_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpgc_top_chk
  import gpgc_pkg::*;
#(
  parameter int unsigned N_PINS = 8
) (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  // pads and overrides
  input wire logic [N_PINS-1:0] pad_out,
  input wire logic [N_PINS-1:0] pad_oe,
  input wire logic [N_PINS-1:0] pad_pull_up,
  input wire logic [N_PINS-1:0] pad_input_en,
  input wire logic [N_PINS-1:0] periph_oe_take,
  input wire logic [N_PINS-1:0] periph_oe_val,
  input wire logic [N_PINS-1:0] periph_out_take,
  input wire logic [N_PINS-1:0] periph_out_val,
  // staged mirror and request
  input wire logic staged_in_we,
  input wire logic [7:0] staged_in_data,
  input wire logic [7:0] staged_out_data,
  input wire logic pin_irq
);
  logic wq, next_wq, cmt;
  logic [7:0] iq, next_iq, wd;
  // data phase remembers what its address phase asked for
  always_comb begin
    next_wq = wq;
    next_iq = iq;
    if (hsel && htrans == GPGC_HTRANS_NONSEQ && hready && hreadyout) begin
      next_wq = hwrite;
      next_iq = haddr[9:2];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wq <= 1'b0;
      iq <= 8'h00;
    end else begin
      wq <= next_wq;
      iq <= next_iq;
    end
  end
  assign wd = hwdata[7:0];
  // an override would mask the strobe effect on the pads
  assign cmt = !hreadyout && wq && periph_oe_take == '0;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rst; $rose(hresetn) |-> pad_oe == '0 && pad_input_en == '1; endproperty
  a_rst: assert property (p_rst) else $error("pads busy after reset");
  property p_set; cmt && iq == GPGC_IDX_DRV_EN_SET |=> ##1 pad_oe == ($past(pad_oe) | $past(wd, 2)); endproperty
  a_set: assert property (p_set) else $error("enable set strobe wrong");
  property p_clr; cmt && iq == GPGC_IDX_DRV_EN_CLR |=> ##1 pad_oe == ($past(pad_oe) & ~$past(wd, 2)); endproperty
  a_clr: assert property (p_clr) else $error("enable clear strobe wrong");
  property p_tgl; cmt && iq == GPGC_IDX_DRV_EN_TGL |=> ##1 pad_oe == ($past(pad_oe) ^ $past(wd, 2)); endproperty
  a_tgl: assert property (p_tgl) else $error("enable toggle strobe wrong");
  property p_pull; $past(periph_oe_take) == '0 |-> (pad_pull_up & pad_oe) == '0; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on a driving pin");
  property p_ovo; periph_out_take != '0 |=> ((pad_out ^ $past(periph_out_val)) & $past(periph_out_take)) == '0;
  endproperty
  a_ovo: assert property (p_ovo) else $error("level override ignored");
  property p_ove; periph_oe_take != '0 |=> ((pad_oe ^ $past(periph_oe_val)) & $past(periph_oe_take)) == '0;
  endproperty
  a_ove: assert property (p_ove) else $error("direction override ignored");
  property p_stg; staged_in_we && hreadyout |=> staged_out_data == ($past(staged_in_data) & GPGC_CFG_USED_MASK);
  endproperty
  a_stg: assert property (p_stg) else $error("mirrored staged write lost");
  c_irq: cover property ($rose(pin_irq));
  c_tgl: cover property (cmt && iq == GPGC_IDX_DRV_EN_TGL);
  c_ovr: cover property (periph_out_take != '0 && periph_oe_take != '0);
endmodule
bind gpgc_top gpgc_top_chk #(.N_PINS(N_PINS)) gpgc_top_chk_i (.*);
`default_nettype wire

// ---- verif/gpio_pin_group_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_group_control_tb;
  import gpgc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, staged_in_we = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [7:0] periph_oe_take = 8'h00, periph_oe_val = 8'h00, periph_out_take = 8'h00, periph_out_val = 8'h00;
  logic [7:0] ext_drv = 8'h00, ext_val = 8'h00, staged_in_data = 8'h00;
  logic hreadyout, pad_slew_limit, staged_out_we, pin_irq;
  logic [1:0] hresp;
  logic [31:0] hrdata, r;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_input_en, pad_thresh_ttl, pin_signal, staged_out_data;
  logic [7:0] en = 8'h00, lvl = 8'h00, d, s, m, t, pu, tt, pol;
  logic [7:0] cfg [8];
  int miscompares = 0;
  int checks_done = 0;
  int op;

  always #5 hclk = ~hclk;

  gpgc_top gpgc_top_i (.hsize(3'h2), .hready(hreadyout), .*);
  gpgc_pad_model gpgc_pad_model_i (.clk(hclk), .*);

  // strobe and bulk effects: 0 load, 1 or, 2 and-not, 3 invert
  function automatic logic [7:0] upd(input int o, input logic [7:0] c, input logic [7:0] x);
    case (o)
      0: return x;
      1: return c | x;
      2: return c & ~x;
      default: return c ^ x;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] dt);
    hsel <= 1'b1;
    htrans <= GPGC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] dt);
    xfer(1'b1, i, dt);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    chk(r, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h37942bd7));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(pad_oe, 8'h00);
    chk(pad_input_en, 8'hff);
    for (int k = 0; k < 60; k++) begin
      op = $urandom_range(4);
      d = 8'($urandom);
      if (k[0]) begin
        // index 8 is the sampled input, whose write toggles the level
        wr(op == 0 && k[1] ? GPGC_IDX_ALIAS_DRV_LVL : GPGC_IDX_DRV_LVL + 8'(op), {24'h0, d});
        lvl = upd(op == 4 ? 3 : op, lvl, d);
        rd(k[1] ? GPGC_IDX_ALIAS_DRV_LVL : GPGC_IDX_DRV_LVL, {24'h0, lvl});
      end else begin
        op = op % 4;
        wr(op == 0 && k[1] ? GPGC_IDX_ALIAS_DRV_EN : GPGC_IDX_DRV_EN + 8'(op), {24'h0, d});
        en = upd(op, en, d);
        rd(k[1] ? GPGC_IDX_ALIAS_DRV_EN : GPGC_IDX_DRV_EN, {24'h0, en});
      end
      chk(pad_oe, en);
      chk(pad_out, lvl);
    end
    t = 8'($urandom);
    ext_drv <= ~en;
    ext_val <= t;
    idle(10);
    rd(GPGC_IDX_SAMPLED_IN, {24'h0, (en & lvl) | (~en & t)});
    rd(GPGC_IDX_ALIAS_SAMPLED_IN, {24'h0, (en & lvl) | (~en & t)});
    for (int n = 0; n < 8; n++) begin
      cfg[n] = 8'($urandom) & GPGC_CFG_USED_MASK;
      pu[n] = cfg[n][GPGC_CFG_PULLUP_BIT];
      tt[n] = cfg[n][GPGC_CFG_THRESH_BIT];
      pol[n] = cfg[n][GPGC_CFG_POLARITY_BIT];
      wr(GPGC_IDX_PIN_CFG_BASE + 8'(n), {24'h0, cfg[n]});
    end
    idle(2);
    chk(pad_pull_up, pu & ~en);
    chk(pad_thresh_ttl, tt);
    chk(pad_out, lvl ^ pol);
    for (op = 0; op < 3; op++) begin
      s = 8'($urandom) & GPGC_CFG_USED_MASK;
      m = 8'($urandom);
      wr(GPGC_IDX_STAGED_SETUP, {24'h0, s});
      wr(GPGC_IDX_BULK_COPY + 8'(op), {24'h0, m});
      for (int n = 0; n < 8; n++) begin
        if (m[n]) cfg[n] = upd(op, cfg[n], s);
        rd(GPGC_IDX_PIN_CFG_BASE + 8'(n), {24'h0, cfg[n]});
      end
    end
    wr(GPGC_IDX_STAGED_SETUP, 32'h0);
    wr(GPGC_IDX_BULK_COPY, 32'hff);
    wr(GPGC_IDX_DRV_EN, 32'h0);
    en = 8'h00;
    ext_drv <= 8'hff;
    ext_val <= 8'h00;
    idle(10);
    chk(pin_signal, 8'h00);
    wr(GPGC_IDX_STAGED_SETUP, 32'h80);
    chk(staged_out_we, 1'b1);
    chk(staged_out_data, 8'h80);
    wr(GPGC_IDX_BULK_COPY, 32'h04);
    idle(10);
    chk(pin_signal, 8'h04);
    rd(GPGC_IDX_SAMPLED_IN, 32'h04);
    wr(GPGC_IDX_BULK_ANDNOT, 32'h04);
    idle(10);
    wr(GPGC_IDX_EVENT_FLAGS, 32'hff);
    wr(GPGC_IDX_PIN_CFG_BASE + 8'h01, {29'h0, GPGC_SENSE_RISE});
    ext_val <= 8'h02;
    idle(10);
    rd(GPGC_IDX_EVENT_FLAGS, 32'h02);
    chk(pin_irq, 1'b1);
    idle(2);
    wr(GPGC_IDX_ALIAS_EVENT_FLAGS, 32'h02);
    ext_val <= 8'h00;
    idle(10);
    chk(pin_irq, 1'b0);
    rd(GPGC_IDX_EVENT_FLAGS, 32'h0);
    wr(GPGC_IDX_STAGED_SETUP, {29'h0, GPGC_SENSE_DISABLE});
    wr(GPGC_IDX_BULK_COPY, 32'hff);
    idle(2);
    chk(pad_input_en, 8'h00);
    ext_val <= 8'hff;
    idle(10);
    rd(GPGC_IDX_SAMPLED_IN, 32'h0);
    chk(pin_signal, 8'h00);
    wr(GPGC_IDX_GROUP_CTRL, 32'h1);
    idle(2);
    chk(pad_slew_limit, 1'b1);
    staged_in_we <= 1'b1;
    staged_in_data <= 8'h4a;
    idle(1);
    staged_in_we <= 1'b0;
    idle(1);
    rd(GPGC_IDX_STAGED_SETUP, 32'h4a);
    t = 8'($urandom);
    d = 8'($urandom);
    m = 8'($urandom);
    ext_drv <= 8'h00;
    periph_oe_take <= t;
    periph_oe_val <= d;
    periph_out_take <= t;
    periph_out_val <= m;
    idle(2);
    chk(pad_oe, t & d);
    chk(pad_out, (t & m) | (~t & lvl));
    rd(8'h0f, 32'h0);
    chk(hresp, GPGC_HRESP_OKAY);
    finish_test();
  end
endmodule
`default_nettype wire
